//--- sfsf_defines.vh
`ifndef SFSF_DEFINES_VH
`define SFSF_DEFINES_VH

// Command opcodes
`define SFSF_OP_READ 8'h03
`define SFSF_OP_STATUS 8'h05
`define SFSF_OP_WREN 8'h06
`define SFSF_OP_WRDI 8'h04
`define SFSF_OP_PROG 8'h02
`define SFSF_OP_ER4K 8'h20
`define SFSF_OP_ER32K 8'h52
`define SFSF_OP_ER64K 8'hD8
`define SFSF_OP_CHIP 8'hC7
`define SFSF_OP_PROT 8'h36
`define SFSF_OP_UNPROT 8'h39
`define SFSF_OP_GPROT 8'h7E
`define SFSF_OP_GUNPROT 8'h98
`define SFSF_OP_PROTRD 8'h3C
`define SFSF_OP_ID 8'h9F

// Erase spans, minus one
`define SFSF_SPAN_4K 20'h00FFF
`define SFSF_SPAN_32K 20'h07FFF
`define SFSF_SPAN_64K 20'h0FFFF
`define SFSF_SPAN_CHIP 20'hFFFFF

// Status byte fields
`define SFSF_ST_BUSY 0
`define SFSF_ST_WEL 1
`define SFSF_ST_LOCK 2
`define SFSF_ST_FAIL 5

// Reset, erased-byte and protection read-back values
`define SFSF_PROT_RST 16'hFFFF
`define SFSF_ERASED 8'hFF
`define SFSF_PROT_YES 8'hFF
`define SFSF_PROT_NO 8'h00

`endif

//--- sfsf_frontend.v
// Operation
// RULE1: select fall starts, select rise ends operation
// RULE2: deselected: output high impedance, standby
// RULE3: input ignored while deselected
// RULE4: stay active until self-timed cycle ends
// RULE5: sample input on serial clock rise
// RULE6: shift output on serial clock fall
// RULE7: all command, address, data on input
// RULE8: works in clock modes 0 and 3
// RULE9: program 1 to 256 bytes within page
// RULE10: erase 4K, 32K, 64K blocks, whole chip
// RULE11: sixteen 64K sectors, own protection each
// RULE12: protected sector rejects program and erase
// RULE13: global protect and unprotect all sectors
// RULE14: hardware lock freezes protected sectors
// RULE15: verify program, report readable failure flag
// RULE16: identification command returns maker, device codes
// RULE17: write-lock active low, floating reads high
// RULE18: opcode byte, then address, MSB first
`timescale 1ns/1ps
`include "sfsf_defines.vh"

module sfsf_frontend #(
   parameter MEM_AW = 20,
   parameter [7:0] MFR_ID = 8'h5A,   // Arbitrary value
   parameter [15:0] DEV_ID = 16'hA501 // Arbitrary value
) (
   input wire clk_sys_i,
   input wire reset_n_i,
   input wire cs_n_i,
   input wire sck_i,
   input wire si_i,
   input wire wlock_n_i,
   output wire so_o,
   output wire so_oe_o,
   output wire busy_o,
   output wire standby_o
);

   // ****************************************
   // Local constants
   // ****************************************
   localparam PH_CMD = 2'b00;
   localparam PH_ADDR = 2'b01;
   localparam PH_DATA = 2'b10;
   localparam PH_IGN = 2'b11;
   localparam EX_IDLE = 2'b00;
   localparam EX_PROG = 2'b01;
   localparam EX_ERASE = 2'b10;

   // ****************************************
   // Decode helpers
   // ****************************************
   function needs_addr;
      input [7:0] op;
      begin
         case (op)
            `SFSF_OP_READ, `SFSF_OP_PROG, `SFSF_OP_ER4K, `SFSF_OP_ER32K,
            `SFSF_OP_ER64K, `SFSF_OP_PROT, `SFSF_OP_UNPROT,
            `SFSF_OP_PROTRD: needs_addr = 1'b1;
            default: needs_addr = 1'b0;
         endcase
      end
   endfunction

   function is_read;
      input [7:0] op;
      begin
         case (op)
            `SFSF_OP_READ, `SFSF_OP_STATUS, `SFSF_OP_PROTRD,
            `SFSF_OP_ID: is_read = 1'b1;
            default: is_read = 1'b0;
         endcase
      end
   endfunction

   function [7:0] id_byte;
      input [8:0] idx;
      begin
         case (idx)
            9'h000: id_byte = MFR_ID;
            9'h001: id_byte = DEV_ID[15:8];
            9'h002: id_byte = DEV_ID[7:0];
            default: id_byte = 8'h00;
         endcase
      end
   endfunction

   // ****************************************
   // Pin synchronisers
   // ****************************************
   reg cs_m, cs_s, cs_d;
   reg sck_m, sck_s, sck_d;
   reg si_m, si_s;
   reg wl_m, wl_s;

   always @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cs_m <= 1'b1;
         cs_s <= 1'b1;
         cs_d <= 1'b1;
         sck_m <= 1'b0;
         sck_s <= 1'b0;
         sck_d <= 1'b0;
         si_m <= 1'b0;
         si_s <= 1'b0;
         wl_m <= 1'b1;
         wl_s <= 1'b1; // [RULE17]
      end else begin
         cs_m <= cs_n_i;
         cs_s <= cs_m;
         cs_d <= cs_s;
         sck_m <= sck_i;
         sck_s <= sck_m;
         sck_d <= sck_s;
         si_m <= si_i;
         si_s <= si_m;
         wl_m <= wlock_n_i;
         wl_s <= wl_m;
      end
   end

   wire sel = ~cs_s;
   wire cs_rise = cs_s & ~cs_d; // [RULE1]
   // Edges in either idle level work alike [RULE8]
   wire sck_rise = sel & sck_s & ~sck_d; // [RULE3] [RULE5]
   wire sck_fall = sel & ~sck_s & sck_d; // [RULE6]
   wire lock = ~wl_s; // [RULE14] [RULE17]

   // ****************************************
   // Shared state
   // ****************************************
   reg [7:0] mem [0:(1<<MEM_AW)-1];
   reg [7:0] pb [0:255];
   reg [6:0] rx_shift;
   reg [2:0] bitcnt;
   reg [1:0] phase;
   reg [7:0] cmd;
   reg [1:0] acnt;
   reg [23:0] addr;
   reg [8:0] nb;
   reg [7:0] tx_byte;
   reg so_r;
   reg out_en;
   reg [1:0] ex_state;
   reg [19:0] ex_cnt;
   reg [19:0] ex_last;
   reg [23:0] ex_base;
   reg wel;
   reg fail;
   reg [15:0] prot;

   wire busy = (ex_state != EX_IDLE);
   wire [7:0] rx_byte = {rx_shift, si_s}; // [RULE7] [RULE18]
   wire byte_done = sck_rise & (bitcnt == 3'h7);
   wire [23:0] next_addr = {addr[15:0], rx_byte}; // [RULE18]
   wire [23:0] inc_addr = addr + 24'h000001;
   wire [7:0] status = {2'b00, fail, 2'b00, lock, wel, busy}; // [RULE15]
   wire [7:0] pb_col = addr[7:0] + nb[7:0];

   // ****************************************
   // Serial receive and transmit
   // ****************************************
   always @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rx_shift <= 7'h00;
         bitcnt <= 3'h0;
         phase <= PH_CMD;
         cmd <= 8'h00;
         acnt <= 2'h0;
         addr <= 24'h000000;
         nb <= 9'h000;
         tx_byte <= 8'h00;
         so_r <= 1'b0;
         out_en <= 1'b0;
      end else if (!sel) begin
         bitcnt <= 3'h0; // [RULE3]
         phase <= PH_CMD; // [RULE1]
         out_en <= 1'b0; // [RULE2]
      end else begin
         if (sck_rise) begin
            rx_shift <= rx_byte[6:0]; // [RULE5]
            bitcnt <= bitcnt + 3'h1;
         end
         if (sck_fall) so_r <= tx_byte[3'h7 - bitcnt]; // [RULE6]
         if (byte_done) begin
            case (phase)
               PH_CMD: begin
                  cmd <= rx_byte; // [RULE18]
                  acnt <= 2'h0;
                  nb <= 9'h000;
                  if (busy && rx_byte != `SFSF_OP_STATUS) begin
                     phase <= PH_IGN; // [RULE4]
                  end else if (needs_addr(rx_byte)) begin
                     phase <= PH_ADDR;
                  end else begin
                     phase <= PH_DATA;
                     out_en <= is_read(rx_byte);
                     if (rx_byte == `SFSF_OP_ID) begin
                        tx_byte <= id_byte(9'h000); // [RULE16]
                     end else begin
                        tx_byte <= status;
                     end
                  end
               end
               PH_ADDR: begin
                  addr <= next_addr;
                  acnt <= acnt + 2'h1;
                  if (acnt == 2'h2) begin
                     phase <= PH_DATA;
                     out_en <= is_read(cmd);
                     if (cmd == `SFSF_OP_PROTRD) begin
                        tx_byte <= prot[next_addr[19:16]] ? `SFSF_PROT_YES : `SFSF_PROT_NO;
                     end else begin
                        tx_byte <= mem[next_addr[MEM_AW-1:0]];
                     end
                  end
               end
               PH_DATA: begin
                  case (cmd)
                     `SFSF_OP_READ: begin
                        addr <= inc_addr;
                        tx_byte <= mem[inc_addr[MEM_AW-1:0]];
                     end
                     `SFSF_OP_STATUS: tx_byte <= status;
                     `SFSF_OP_ID: begin
                        nb <= nb + 9'h001;
                        tx_byte <= id_byte(nb + 9'h001); // [RULE16]
                     end
                     `SFSF_OP_PROG: begin
                        // Columns wrap within the page; bytes past 256 all land on the start column [RULE9]
                        pb[pb_col] <= rx_byte;
                        if (nb != 9'h100) begin
                           nb <= nb + 9'h001;
                        end
                     end
                     default: tx_byte <= tx_byte;
                  endcase
               end
               default: phase <= PH_IGN;
            endcase
         end
      end
   end

   // ****************************************
   // Operation end and self-timed execution
   // ****************************************
   wire op_end = cs_rise & (bitcnt == 3'h0) & (phase == PH_DATA) & ~busy; // [RULE1]
   wire [3:0] sec = addr[19:16]; // [RULE11]
   wire [7:0] ex_col = ex_base[7:0] + ex_cnt[7:0];
   wire [23:0] ex_paddr = {ex_base[23:8], ex_col};
   wire [23:0] ex_eaddr = ex_base + {4'h0, ex_cnt};
   wire [MEM_AW-1:0] ex_pidx = ex_paddr[MEM_AW-1:0];
   wire [MEM_AW-1:0] ex_eidx = ex_eaddr[MEM_AW-1:0];
   reg [19:0] next_span;

   always @* begin
      case (cmd)
         `SFSF_OP_ER4K: next_span = `SFSF_SPAN_4K;
         `SFSF_OP_ER32K: next_span = `SFSF_SPAN_32K;
         `SFSF_OP_ER64K: next_span = `SFSF_SPAN_64K;
         default: next_span = `SFSF_SPAN_CHIP;
      endcase
   end

   always @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ex_state <= EX_IDLE;
         ex_cnt <= 20'h00000;
         ex_last <= 20'h00000;
         ex_base <= 24'h000000;
         wel <= 1'b0;
         fail <= 1'b0;
         prot <= `SFSF_PROT_RST;
      end else begin
         case (ex_state)
            EX_IDLE: begin
               if (op_end) begin
                  case (cmd)
                     `SFSF_OP_WREN: wel <= 1'b1;
                     `SFSF_OP_WRDI: wel <= 1'b0;
                     `SFSF_OP_PROG: begin
                        wel <= 1'b0;
                        if (wel && !prot[sec] && nb != 9'h000) begin // [RULE12]
                           ex_state <= EX_PROG; // [RULE9]
                           ex_base <= addr;
                           ex_cnt <= 20'h00000;
                           ex_last <= {11'h000, nb - 9'h001};
                           fail <= 1'b0;
                        end
                     end
                     `SFSF_OP_ER4K, `SFSF_OP_ER32K, `SFSF_OP_ER64K: begin
                        wel <= 1'b0;
                        if (wel && !prot[sec]) begin // [RULE12]
                           ex_state <= EX_ERASE; // [RULE10]
                           ex_base <= addr & ~{4'h0, next_span};
                           ex_cnt <= 20'h00000;
                           ex_last <= next_span;
                           fail <= 1'b0;
                        end
                     end
                     `SFSF_OP_CHIP: begin
                        wel <= 1'b0;
                        if (wel && prot == 16'h0000) begin // [RULE12]
                           ex_state <= EX_ERASE; // [RULE10]
                           ex_base <= 24'h000000;
                           ex_cnt <= 20'h00000;
                           ex_last <= next_span;
                           fail <= 1'b0;
                        end
                     end
                     `SFSF_OP_PROT: begin
                        wel <= 1'b0;
                        if (wel) prot[sec] <= 1'b1; // [RULE12]
                     end
                     `SFSF_OP_UNPROT: begin
                        wel <= 1'b0;
                        if (wel && !lock) prot[sec] <= 1'b0; // [RULE12] [RULE14]
                     end
                     `SFSF_OP_GPROT: begin
                        wel <= 1'b0;
                        if (wel) prot <= 16'hFFFF; // [RULE13]
                     end
                     `SFSF_OP_GUNPROT: begin
                        wel <= 1'b0;
                        if (wel && !lock) prot <= 16'h0000; // [RULE13] [RULE14]
                     end
                     default: wel <= wel;
                  endcase
               end
            end
            EX_PROG: begin
               // Cells only clear; a data bit of 1 over a cell already at 0 fails verify [RULE15]
               mem[ex_pidx] <= mem[ex_pidx] & pb[ex_col];
               if ((pb[ex_col] & ~mem[ex_pidx]) != 8'h00) begin
                  fail <= 1'b1; // [RULE15]
               end
               ex_cnt <= ex_cnt + 20'h00001;
               if (ex_cnt == ex_last) begin
                  ex_state <= EX_IDLE;
               end
            end
            EX_ERASE: begin
               mem[ex_eidx] <= `SFSF_ERASED; // [RULE10]
               if (ex_cnt != 20'h00000 && mem[ex_eidx - 1'b1] != `SFSF_ERASED) begin
                  fail <= 1'b1; // [RULE15]
               end
               ex_cnt <= ex_cnt + 20'h00001;
               if (ex_cnt == ex_last) begin
                  ex_state <= EX_IDLE;
               end
            end
            default: ex_state <= EX_IDLE;
         endcase
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign so_o = so_r;
   assign so_oe_o = sel & out_en; // [RULE2]
   assign busy_o = busy;
   assign standby_o = cs_s & ~busy; // [RULE2] [RULE4]

endmodule // sfsf_frontend

//--- sfsf_monitor.sv
`timescale 1ns/1ps
module sfsf_monitor (
   input wire clk_sys_i,
   input wire reset_n_i,
   input wire cs_n_i,
   input wire sck_i,
   input wire si_i,
   input wire wlock_n_i,
   input wire so_o,
   input wire so_oe_o,
   input wire busy_o,
   input wire standby_o
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!reset_n_i);
   a_oe_off_desel:
      assert property ($rose(cs_n_i) |-> ##[1:6] !so_oe_o) else $error("so drive stuck");
   a_idle_standby:
      assert property (cs_n_i [*6] ##0 !busy_o |-> standby_o) else $error("no standby");
   a_busy_active:
      assert property (busy_o |-> !standby_o) else $error("standby while busy");
   a_busy_start:
      assert property ($rose(busy_o) |-> cs_n_i && $past(cs_n_i, 2)) else $error("busy early");
   a_busy_done_standby:
      assert property ($fell(busy_o) && $past(cs_n_i, 2) |-> standby_o)
         else $error("no standby after busy");
   a_select_wakes:
      assert property ($fell(cs_n_i) |-> ##[1:4] !standby_o) else $error("select ignored");
   a_oe_drop_desel:
      assert property ($fell(so_oe_o) |-> cs_n_i) else $error("so drive dropped");
   a_oe_after_rise:
      assert property ($rose(so_oe_o) |-> !cs_n_i && sck_i) else $error("so drive timing");
   a_so_hold_high:
      assert property (sck_i [*4] ##0 (so_oe_o && $past(so_oe_o, 5)) |-> $stable(so_o))
         else $error("so moved on rise");
endmodule // sfsf_monitor

bind sfsf_frontend sfsf_monitor u_mon (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
   .cs_n_i(cs_n_i), .sck_i(sck_i), .si_i(si_i), .wlock_n_i(wlock_n_i), .so_o(so_o),
   .so_oe_o(so_oe_o), .busy_o(busy_o), .standby_o(standby_o));

//--- sfsf_host_model.sv
`timescale 1ns/1ps
module sfsf_host_model (
   input wire clk_i,
   input wire so_i,
   output reg cs_n_o,
   output reg sck_o,
   output reg si_o,
   output reg [7:0] rx_data_o,
   output reg rx_valid_o
);
   logic [7:0] txq[$];
   initial begin
      cs_n_o = 1'b1;
      sck_o = 1'b0;
      si_o = 1'b0;
      rx_data_o = 8'h00;
      rx_valid_o = 1'b0;
   end
   // ****************************************
   // Deselected line noise
   // ****************************************
   task automatic noise(input logic [31:0] pat);
      int i;
      for (i = 0; i < 32; i++) begin
         @(posedge clk_i);
         si_o <= pat[i];
         sck_o <= i[2];
      end
      @(posedge clk_i);
      sck_o <= 1'b0;
   endtask
   // ****************************************
   // One framed operation, reads after writes
   // ****************************************
   task automatic frame(input bit mode3, input int n_rd);
      logic [7:0] b;
      int i;
      int j;
      @(posedge clk_i);
      sck_o <= mode3;
      repeat (4) @(posedge clk_i);
      cs_n_o <= 1'b0;
      repeat (4) @(posedge clk_i);
      for (i = 0; i < txq.size() + n_rd; i++) begin
         b = (i < txq.size()) ? txq[i] : 8'h00;
         for (j = 7; j >= 0; j--) begin
            sck_o <= 1'b0;
            si_o <= b[j];
            repeat (4) @(posedge clk_i);
            sck_o <= 1'b1;
            @(posedge clk_i);
            b[j] = so_i;
            repeat (3) @(posedge clk_i);
         end
         if (i >= txq.size()) begin
            rx_data_o <= b;
            rx_valid_o <= 1'b1;
            @(posedge clk_i);
            rx_valid_o <= 1'b0;
         end
      end
      sck_o <= mode3;
      repeat (4) @(posedge clk_i);
      cs_n_o <= 1'b1;
      si_o <= ~si_o;
      repeat (8) @(posedge clk_i);
   endtask
endmodule // sfsf_host_model

//--- tb_top.sv
`timescale 1ns/1ps
`include "sfsf_defines.vh"
module tb_top;
   localparam [7:0] MFR = 8'h3C; // Arbitrary value
   localparam [15:0] DEV = 16'h7E12; // Arbitrary value
   reg clk_sys_i = 1'b0;
   reg reset_n_i = 1'b0;
   reg wlock_n_i = 1'b1;
   wire cs_n, sck, si, so_o, so_oe_o, busy_o, standby_o, rx_valid;
   wire [7:0] rx_data;
   wire so_w = so_oe_o ? so_o : 1'bz;
   logic [7:0] exp_q[$];
   logic [7:0] msk_q[$];
   logic [31:0] rnd = 32'hA1ED;
   logic [7:0] d0, d1, d2;
   int err_total = 0;
   int cmp_count = 0;
   int m;
   always #20 clk_sys_i = ~clk_sys_i;
   sfsf_frontend #(.MEM_AW(12), .MFR_ID(MFR), .DEV_ID(DEV)) u_dut (.clk_sys_i(clk_sys_i),
      .reset_n_i(reset_n_i), .cs_n_i(cs_n), .sck_i(sck), .si_i(si), .wlock_n_i(wlock_n_i),
      .so_o(so_o), .so_oe_o(so_oe_o), .busy_o(busy_o), .standby_o(standby_o));
   sfsf_host_model u_host (.clk_i(clk_sys_i), .so_i(so_w), .cs_n_o(cs_n), .sck_o(sck),
      .si_o(si), .rx_data_o(rx_data), .rx_valid_o(rx_valid));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic finish_test;
      $display("Compares %0d, mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic want(input logic [7:0] e, input logic [7:0] k = 8'hFF);
      exp_q.push_back(e);
      msk_q.push_back(k);
   endtask
   task automatic send(input logic [7:0] b[$], input int n_rd, input bit m3 = 1'b0);
      u_host.txq = b;
      u_host.frame(m3, n_rd);
   endtask
   task automatic settle(input string name);
      int n;
      for (n = 0; n < 40000 && (busy_o !== 1'b0 || exp_q.size() > 0); n++) @(posedge clk_sys_i);
      if (n == 40000) begin
         err_total++;
         finish_test;
      end else if (name != "") begin
         $display("Test %s done", name);
      end
   endtask
   // ****************************************
   // Result watcher
   // ****************************************
   always @(posedge clk_sys_i) begin
      if (rx_valid) begin
         if (exp_q.size() == 0) check(8'h00, 8'h01);
         else check(rx_data & msk_q.pop_front(), exp_q.pop_front());
      end
   end
   initial begin
      repeat (16) @(posedge clk_sys_i);
      reset_n_i <= 1'b1;
      repeat (4) @(posedge clk_sys_i);
      for (m = 0; m < 2; m++) begin
         want(MFR);
         want(DEV[15:8]);
         want(DEV[7:0]);
         send({`SFSF_OP_ID}, 3, m[0]);
      end
      settle("ident");
      u_host.noise(rnd);
      want(8'h00);
      send({`SFSF_OP_STATUS}, 1);
      want(`SFSF_PROT_YES);
      send({`SFSF_OP_PROTRD, 8'h01, 8'h00, 8'h00}, 1);
      settle("reset state");
      send({`SFSF_OP_WREN}, 0);
      send({`SFSF_OP_GUNPROT}, 0);
      want(`SFSF_PROT_NO);
      send({`SFSF_OP_PROTRD, 8'h01, 8'h00, 8'h00}, 1);
      send({`SFSF_OP_WREN}, 0);
      send({`SFSF_OP_ER4K, 8'h01, 8'h00, 8'h00}, 0);
      settle("");
      want(`SFSF_ERASED);
      want(`SFSF_ERASED);
      send({`SFSF_OP_READ, 8'h01, 8'h00, 8'hFE}, 2);
      settle("erase");
      rnd = lfsr(rnd);
      d0 = rnd[7:0] & 8'h7F;
      d1 = rnd[15:8];
      d2 = rnd[23:16];
      send({`SFSF_OP_WREN}, 0);
      send({`SFSF_OP_PROG, 8'h01, 8'h00, 8'hFE, d0, d1, d2}, 0);
      settle("");
      want(d0);
      want(d1);
      send({`SFSF_OP_READ, 8'h01, 8'h00, 8'hFE}, 2);
      want(d2);
      send({`SFSF_OP_READ, 8'h01, 8'h00, 8'h00}, 1);
      send({`SFSF_OP_WREN}, 0);
      send({`SFSF_OP_PROG, 8'h01, 8'h00, 8'hFE, 8'hFF}, 0);
      settle("");
      want(8'h20, 8'h20);
      send({`SFSF_OP_STATUS}, 1);
      settle("program");
      send({`SFSF_OP_WREN}, 0);
      send({`SFSF_OP_PROT, 8'h01, 8'h00, 8'h00}, 0);
      send({`SFSF_OP_WREN}, 0);
      send({`SFSF_OP_PROG, 8'h01, 8'h00, 8'hFF, 8'h00}, 0);
      settle("");
      want(d1);
      send({`SFSF_OP_READ, 8'h01, 8'h00, 8'hFF}, 1);
      wlock_n_i <= 1'b0;
      want(8'h04, 8'h04);
      send({`SFSF_OP_STATUS}, 1);
      send({`SFSF_OP_WREN}, 0);
      send({`SFSF_OP_UNPROT, 8'h01, 8'h00, 8'h00}, 0);
      want(`SFSF_PROT_YES);
      send({`SFSF_OP_PROTRD, 8'h01, 8'h00, 8'h00}, 1);
      wlock_n_i <= 1'b1;
      send({`SFSF_OP_WREN}, 0);
      send({`SFSF_OP_UNPROT, 8'h01, 8'h00, 8'h00}, 0);
      want(`SFSF_PROT_NO);
      send({`SFSF_OP_PROTRD, 8'h01, 8'h00, 8'h00}, 1);
      settle("protection");
      send({`SFSF_OP_WREN}, 0);
      send({`SFSF_OP_ER32K, 8'h01, 8'h00, 8'hFE}, 0);
      want(8'h01);
      send({`SFSF_OP_STATUS}, 1);
      settle("");
      want(`SFSF_ERASED);
      send({`SFSF_OP_READ, 8'h01, 8'h00, 8'hFE}, 1);
      send({`SFSF_OP_WREN}, 0);
      send({`SFSF_OP_WRDI}, 0);
      want(8'h00);
      send({`SFSF_OP_STATUS}, 1);
      settle("block erase");
      send({`SFSF_OP_WREN}, 0);
      send({`SFSF_OP_GPROT}, 0);
      want(`SFSF_PROT_YES);
      send({`SFSF_OP_PROTRD, 8'h05, 8'h00, 8'h00}, 1);
      send({`SFSF_OP_WREN}, 0);
      send({`SFSF_OP_CHIP}, 0);
      want(8'h00);
      send({`SFSF_OP_STATUS}, 1);
      settle("global");
      send({`SFSF_OP_WREN}, 0);
      send({`SFSF_OP_GUNPROT}, 0);
      send({`SFSF_OP_WREN}, 0);
      reset_n_i <= 1'b0;
      repeat (2) @(posedge clk_sys_i);
      reset_n_i <= 1'b1;
      repeat (4) @(posedge clk_sys_i);
      want(`SFSF_PROT_YES);
      send({`SFSF_OP_PROTRD, 8'h01, 8'h00, 8'h00}, 1);
      want(8'h00);
      send({`SFSF_OP_STATUS}, 1);
      settle("mid reset");
      finish_test;
   end
endmodule // tb_top
